// ### abx_exec.sv
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module abx_exec
   import abx_pkg::*;
#(
   parameter int PORT_ADDR = 6
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [7:0]  port_pins,
   output logic [7:0]       port_out,
   output logic             skip_req,
   output logic             idle_slot
);

   if (PORT_ADDR < 0 || PORT_ADDR > 127) begin : g_chk
      $error("PORT_ADDR must lie in 0 to 127");
   end
   localparam logic [6:0] PORT_IDX = 7'(PORT_ADDR);
   typedef struct packed {
      abx_state_t       state;
      logic [13:0]      instr;
      logic [7:0]       acc;
      logic             c;
      logic             nib;
      logic             z;
      logic             discard;
      logic             illegal;
      logic [127:0][7:0] file;
      logic [2:0][7:0]  pin_sync;
      logic [7:0]       pin_val;
      logic             skip_req;
      logic             idle_slot;
      logic             awready;
      logic             wready;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             arready;
      logic             rvalid;
      logic [1:0]       rresp;
      logic [31:0]      rdata;
   } abx_regs_t;
   abx_regs_t r_reg;
   abx_regs_t r_next;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b);
      logic [4:0] lo;
      logic [8:0] full;
      lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      full = {1'b0, a} + {1'b0, b};
      return {full[8], lo[4], full[7:0]};
   endfunction
   function automatic logic [8:0] map_addr(input logic [11:0] a);
      // Bit 8 marks a file register hit, low bits give its index
      if (a >= ABX_FILE_OFS && a <= ABX_FILE_END && a[1:0] == 2'h0) begin
         return {1'b1, 1'b0, a[8:2]};
      end
      return 9'h000;
   endfunction

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic [6:0] fa;
      logic [2:0] bsel;
      logic [7:0] opnd;
      logic [7:0] res;
      logic [9:0] sum;
      logic [8:0] wmap;
      logic [8:0] rmap;
      logic       bitv;
      logic       dest_file;
      fa        = r_reg.instr[6:0];
      bsel      = r_reg.instr[9:7];
      dest_file = r_reg.instr[7];
      opnd      = (fa == PORT_IDX) ? r_reg.pin_val : r_reg.file[fa];
      bitv      = opnd[bsel];
      sum       = 10'h000;
      res       = 8'h00;
      wmap      = map_addr(s_axi_awaddr);
      rmap      = map_addr(s_axi_araddr);
      r_next    = r_reg;
      r_next.skip_req  = 1'b0;
      r_next.idle_slot = 1'b0;

      // Pin synchroniser, accepted once stages two and three agree
      r_next.pin_sync = {r_reg.pin_sync[1:0], port_pins};
      if (r_reg.pin_sync[1] == r_reg.pin_sync[2]) begin
         r_next.pin_val = r_reg.pin_sync[2];
      end

      // ------------------------------------------------------------
      // AXI write channel
      // ------------------------------------------------------------
      r_next.awready = 1'b0;
      r_next.wready  = 1'b0;
      if (r_reg.bvalid && s_axi_bready) begin
         r_next.bvalid = 1'b0;
      end
      if (s_axi_awvalid && s_axi_wvalid && !r_reg.bvalid && !r_reg.awready) begin
         r_next.awready = 1'b1;
         r_next.wready  = 1'b1;
         r_next.bvalid  = 1'b1;
         r_next.bresp   = ABX_RESP_OKAY;
         if (s_axi_awaddr == ABX_INSTR_OFS) begin
            if (r_reg.state == ABX_ST_IDLE && s_axi_wstrb[1:0] == 2'h3) begin
               r_next.instr = s_axi_wdata[13:0];
               r_next.state = ABX_ST_EXEC;
            end
         end else if (s_axi_awaddr == ABX_ACC_OFS) begin
            if (s_axi_wstrb[0]) begin
               r_next.acc = s_axi_wdata[7:0];
            end
            if (s_axi_wstrb[1]) begin
               r_next.c   = s_axi_wdata[ABX_ST_C_POS];
               r_next.nib = s_axi_wdata[ABX_ST_NIB_POS];
               r_next.z   = s_axi_wdata[ABX_ST_Z_POS];
            end
         end else if (wmap[8]) begin
            if (s_axi_wstrb[0]) begin
               r_next.file[wmap[6:0]] = s_axi_wdata[7:0];
            end
         end else if (s_axi_awaddr != ABX_STATUS_OFS) begin
            r_next.bresp = ABX_RESP_SLVERR;
         end
      end

      // ------------------------------------------------------------
      // AXI read channel
      // ------------------------------------------------------------
      r_next.arready = 1'b0;
      if (r_reg.rvalid && s_axi_rready) begin
         r_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !r_reg.rvalid && !r_reg.arready) begin
         r_next.arready = 1'b1;
         r_next.rvalid  = 1'b1;
         r_next.rresp   = ABX_RESP_OKAY;
         r_next.rdata   = 32'h0000_0000;
         if (s_axi_araddr == ABX_INSTR_OFS) begin
            r_next.rdata[13:0] = r_reg.instr;
         end else if (s_axi_araddr == ABX_STATUS_OFS || s_axi_araddr == ABX_ACC_OFS) begin
            r_next.rdata[7:0]                  = r_reg.acc;
            r_next.rdata[ABX_ST_C_POS]         = r_reg.c;
            r_next.rdata[ABX_ST_NIB_POS]       = r_reg.nib;
            r_next.rdata[ABX_ST_Z_POS]         = r_reg.z;
            r_next.rdata[ABX_ST_BUSY_POS]      = (r_reg.state != ABX_ST_IDLE);
            r_next.rdata[ABX_ST_DISCARD_POS]   = r_reg.discard;
            r_next.rdata[ABX_ST_ILLEGAL_POS]   = r_reg.illegal;
         end else if (rmap[8]) begin
            r_next.rdata[7:0] = (rmap[6:0] == PORT_IDX) ? r_reg.pin_val
                                                        : r_reg.file[rmap[6:0]];
         end else begin
            r_next.rresp = ABX_RESP_SLVERR;
         end
      end

      // ------------------------------------------------------------
      // Execution
      // ------------------------------------------------------------
      case (r_reg.state)
         ABX_ST_IDLE: begin
         end
         ABX_ST_EXEC: begin
            r_next.state   = ABX_ST_IDLE;
            r_next.illegal = 1'b0;
            if (r_reg.discard) begin
               r_next.discard   = 1'b0;
               r_next.idle_slot = 1'b1;
            end else if (r_reg.instr[13:9] == ABX_OP_ADD_LIT) begin
               sum         = add8(r_reg.acc, r_reg.instr[7:0]);
               r_next.acc  = sum[7:0];
               r_next.c    = sum[9];
               r_next.nib  = sum[8];
               r_next.z    = (sum[7:0] == 8'h00);
            end else if (r_reg.instr[13:8] == ABX_OP_AND_LIT) begin
               res        = r_reg.acc & r_reg.instr[7:0];
               r_next.acc = res;
               r_next.z   = (res == 8'h00);
            end else if (r_reg.instr[13:8] == ABX_OP_ADD_FILE ||
                         r_reg.instr[13:8] == ABX_OP_AND_FILE) begin
               sum = add8(r_reg.acc, opnd);
               if (r_reg.instr[13:8] == ABX_OP_ADD_FILE) begin
                  res       = sum[7:0];
                  r_next.c   = sum[9];
                  r_next.nib = sum[8];
               end else begin
                  res = r_reg.acc & opnd;
               end
               r_next.z = (res == 8'h00);
               if (dest_file) begin
                  r_next.file[fa] = res;
               end else begin
                  r_next.acc = res;
               end
            end else begin
               case (r_reg.instr[13:10])
                  ABX_OP_BIT_CLEAR: begin
                     res             = opnd;
                     res[bsel]       = 1'b0;
                     r_next.file[fa] = res;
                  end
                  ABX_OP_BIT_SET: begin
                     res             = opnd;
                     res[bsel]       = 1'b1;
                     r_next.file[fa] = res;
                  end
                  ABX_OP_SKIP_LOW: begin
                     if (!bitv) begin
                        r_next.state    = ABX_ST_SKIP;
                        r_next.skip_req = 1'b1;
                        r_next.discard  = 1'b1;
                     end
                  end
                  ABX_OP_SKIP_HIGH: begin
                     if (bitv) begin
                        r_next.state    = ABX_ST_SKIP;
                        r_next.skip_req = 1'b1;
                        r_next.discard  = 1'b1;
                     end
                  end
                  default: begin
                     r_next.illegal = 1'b1;
                  end
               endcase
            end
         end
         ABX_ST_SKIP: begin
            r_next.idle_slot = 1'b1;
            r_next.state     = ABX_ST_IDLE;
         end
         default: begin
            r_next.state = ABX_ST_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r_reg       <= '0;
         r_reg.state <= ABX_ST_IDLE;
         r_reg.instr <= ABX_INSTR_RST;
         r_reg.acc   <= ABX_ACC_RST;
         r_reg.file  <= {128{ABX_FILE_RST}};
      end else begin
         r_reg <= r_next;
      end
   end
   // Port latch is the stored file register at the port index
   assign port_out      = r_reg.file[PORT_IDX];
   assign skip_req      = r_reg.skip_req;
   assign idle_slot     = r_reg.idle_slot;
   assign s_axi_awready = r_reg.awready;
   assign s_axi_wready  = r_reg.wready;
   assign s_axi_bvalid  = r_reg.bvalid;
   assign s_axi_bresp   = r_reg.bresp;
   assign s_axi_arready = r_reg.arready;
   assign s_axi_rvalid  = r_reg.rvalid;
   assign s_axi_rresp   = r_reg.rresp;
   assign s_axi_rdata   = r_reg.rdata;

endmodule // abx_exec

// ### abx_pkg.sv
package abx_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] ABX_INSTR_OFS  = 12'h000;
   localparam logic [11:0] ABX_STATUS_OFS = 12'h004;
   localparam logic [11:0] ABX_ACC_OFS    = 12'h008;
   localparam logic [11:0] ABX_FILE_OFS   = 12'h200;
   localparam logic [11:0] ABX_FILE_END   = 12'h3FC;

   // ------------------------------------------------------------
   // Status and accumulator register fields
   // ------------------------------------------------------------
   localparam int ABX_ST_C_POS       = 8;
   localparam int ABX_ST_NIB_POS     = 9;
   localparam int ABX_ST_Z_POS       = 10;
   localparam int ABX_ST_BUSY_POS    = 11;
   localparam int ABX_ST_DISCARD_POS = 12;
   localparam int ABX_ST_ILLEGAL_POS = 13;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0]  ABX_ACC_RST   = 8'h00;
   localparam logic [7:0]  ABX_FILE_RST  = 8'h00;
   localparam logic [13:0] ABX_INSTR_RST = 14'h0000;

   // ------------------------------------------------------------
   // Opcode fields
   // ------------------------------------------------------------
   localparam logic [5:0] ABX_OP_ADD_FILE  = 6'h07;
   localparam logic [5:0] ABX_OP_AND_FILE  = 6'h05;
   localparam logic [5:0] ABX_OP_AND_LIT   = 6'h39;
   localparam logic [4:0] ABX_OP_ADD_LIT   = 5'h1F;
   localparam logic [3:0] ABX_OP_BIT_CLEAR = 4'h4;
   localparam logic [3:0] ABX_OP_BIT_SET   = 4'h5;
   localparam logic [3:0] ABX_OP_SKIP_LOW  = 4'h6;
   localparam logic [3:0] ABX_OP_SKIP_HIGH = 4'h7;

   localparam logic [1:0] ABX_RESP_OKAY   = 2'h0;
   localparam logic [1:0] ABX_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ABX_ST_IDLE = 2'h0,
      ABX_ST_EXEC = 2'h1,
      ABX_ST_SKIP = 2'h3
   } abx_state_t;

endpackage

// ### abx_exec_asserts.sv
`timescale 1ns/1ps
module abx_exec_chk
   import abx_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        skip_req,
   input wire logic        idle_slot
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ------------------------------------------------------------
   // Bus answers
   // ------------------------------------------------------------
   property p_wr_answer;
      s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready
         |=> s_axi_awready && s_axi_wready && s_axi_bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
   property p_rd_answer;
      s_axi_arvalid && !s_axi_rvalid && !s_axi_arready |=> s_axi_arready && s_axi_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   // ------------------------------------------------------------
   // Skip sequencing
   // ------------------------------------------------------------
   property p_skip_cause;
      skip_req |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2);
   endproperty
   a_skip_cause: assert property (p_skip_cause) else $error("skip at wrong time");
   property p_skip_idle;
      skip_req |=> idle_slot ##1 !idle_slot;
   endproperty
   a_skip_idle: assert property (p_skip_idle) else $error("no idle slot after skip");
   property p_skip_pulse;
      skip_req |=> !skip_req;
   endproperty
   a_skip_pulse: assert property (p_skip_pulse) else $error("skip request too long");
   property p_idle_excl;
      idle_slot |-> !skip_req;
   endproperty
   a_idle_excl: assert property (p_idle_excl) else $error("idle slot with skip");
   c_skip: cover property (skip_req);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == ABX_RESP_SLVERR);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // abx_exec_chk

bind abx_exec abx_exec_chk abx_exec_chk_i (
   .aclk          (aclk),
   .aresetn       (aresetn),
   .s_axi_awvalid (s_axi_awvalid),
   .s_axi_wvalid  (s_axi_wvalid),
   .s_axi_awready (s_axi_awready),
   .s_axi_wready  (s_axi_wready),
   .s_axi_bvalid  (s_axi_bvalid),
   .s_axi_bready  (s_axi_bready),
   .s_axi_bresp   (s_axi_bresp),
   .s_axi_arvalid (s_axi_arvalid),
   .s_axi_arready (s_axi_arready),
   .s_axi_rvalid  (s_axi_rvalid),
   .s_axi_rready  (s_axi_rready),
   .s_axi_rdata   (s_axi_rdata),
   .skip_req      (skip_req),
   .idle_slot     (idle_slot)
);

// ### abx_exec_tb.sv
`timescale 1ns/1ps
module abx_exec_tb;
   import abx_pkg::*;
   localparam int pa = 6;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, skip_req, idle_slot, z, nib, c;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [31:0] seed = 32'h0000002D;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [7:0]  port_pins, port_out, acc;
   int          err_count = 0, comparisons = 0, cyc = 0, nskip = 0, nidle = 0;

   abx_exec #(.PORT_ADDR(pa)) abx_exec_i (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .port_pins     (port_pins),
      .port_out      (port_out),
      .skip_req      (skip_req),
      .idle_slot     (idle_slot)
   );

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      nskip <= nskip + int'(skip_req);
      nidle <= nidle + int'(idle_slot);
      if (cyc == 20000) begin
         err_count++;
         summarize();
      end
   end
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [10:0] alu(input logic ad, input logic [7:0] a, b);
      logic [8:0] s;
      s = ad ? {1'b0, a} + {1'b0, b} : {1'b0, a & b};
      return {s[7:0] == 8'h00, ad ? ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F : nib,
              ad ? s[8] : c, s[7:0]};
   endfunction
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready === 1'b1) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rdr(input logic [11:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin @(posedge aclk); end while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic ex(input logic [13:0] i);
      wr(ABX_INSTR_OFS, {18'h0, i}, 4'hF);
      do begin rdr(ABX_STATUS_OFS); end while (rd[ABX_ST_BUSY_POS] !== 1'b0);
   endtask
   task summarize;
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] op, a;
      logic [10:0] r;
      logic [7:0]  lit, fv;
      logic [6:0]  f;
      logic [2:0]  kind, b;
      logic        d, tk;
      int          s0, i0;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, port_pins} <= 68'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rdr(ABX_STATUS_OFS);
      chk({rsp, rd}, 34'h0);
      chk(34'(port_out), 34'h0);
      for (int k = 0; k < 60; k++) begin
         op = xs();
         a = xs();
         kind = (k < 8) ? k[2:0] : op[2:0];
         f = (op[14:8] == 7'(pa)) ? 7'h00 : op[14:8];
         b = op[18:16];
         d = op[19];
         lit = (k < 8) ? 8'hFF : op[31:24];
         if (k < 8) a[7:0] = 8'h01;
         fv = a[23:16];
         tk = 1'b0;
         wr(ABX_ACC_OFS, {21'h0, a[10:0]}, 4'h3);
         chk(34'(rsp), 34'(ABX_RESP_OKAY));
         {z, nib, c, acc} = a[10:0];
         wr(ABX_FILE_OFS + {3'h0, f, 2'b00}, {24'h0, fv}, 4'h1);
         s0 = nskip;
         i0 = nidle;
         r = {z, nib, c, acc};
         case (kind)
            3'h0: ex({ABX_OP_ADD_LIT, 1'b0, lit});
            3'h1: ex({ABX_OP_AND_LIT, lit});
            3'h2: ex({ABX_OP_ADD_FILE, d, f});
            3'h3: ex({ABX_OP_AND_FILE, d, f});
            3'h4: ex({ABX_OP_BIT_CLEAR, b, f});
            3'h5: ex({ABX_OP_BIT_SET, b, f});
            3'h6: ex({ABX_OP_SKIP_LOW, b, f});
            default: ex({ABX_OP_SKIP_HIGH, b, f});
         endcase
         if (kind < 3'h2) r = alu(~kind[0], acc, lit);
         if (kind == 3'h2 || kind == 3'h3) r = alu(~kind[0], acc, fv);
         if ((kind == 3'h2 || kind == 3'h3) && d) {fv, r[7:0]} = {r[7:0], acc};
         if (kind == 3'h4) fv[b] = 1'b0;
         if (kind == 3'h5) fv[b] = 1'b1;
         if (kind > 3'h5) tk = (fv[b] == kind[0]);
         chk(34'(rd), {21'h0, tk, 1'b0, r});
         {z, nib, c, acc} = r;
         rdr(ABX_FILE_OFS + {3'h0, f, 2'b00});
         chk({rsp, rd}, {ABX_RESP_OKAY, 24'h0, fv});
         chk(34'(nskip - s0), 34'(tk));
         if (tk) ex({ABX_OP_ADD_LIT, 1'b0, 8'h01});
         if (tk) chk(34'(rd), {23'h0, r});
         chk(34'(nidle - i0), tk ? 34'h2 : 34'h0);
      end
      port_pins <= 8'hA5;
      wr(ABX_FILE_OFS + 12'(pa * 4), 32'h0000005A, 4'h1);
      repeat (6) @(posedge aclk);
      chk(34'(port_out), 34'h5A);
      rdr(ABX_FILE_OFS + 12'(pa * 4));
      chk(34'(rd), 34'hA5);
      ex({ABX_OP_BIT_SET, 3'h1, 7'(pa)});
      chk(34'(port_out), 34'hA7);
      rdr(12'h100);
      chk({rsp, rd}, {ABX_RESP_SLVERR, 32'h0});
      wr(12'h100, 32'h000000FF, 4'hF);
      chk(34'(rsp), 34'(ABX_RESP_SLVERR));
      ex(14'h0000);
      chk(34'(rd[ABX_ST_ILLEGAL_POS]), 34'h1);
      summarize();
   end
endmodule // abx_exec_tb
